// File: dv/crt_host_model.sv
// Host bus model that writes commands and reads the status byte through the pins.
`timescale 1ns/1ps
module crt_host_model (
  input wire logic clk,
  output logic csN,
  output logic rdN,
  output logic wrN,
  output logic cpSel,
  output logic [7:0] dbIn,
  input wire logic [7:0] dbOut,
  input wire logic dbOe
);
  initial begin
    csN = 1'b1;
    rdN = 1'b1;
    wrN = 1'b1;
    cpSel = 1'b0;
    dbIn = 8'h00;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Strobes stand four cycles, above the two the pin filter needs; it misses only one-cycle ones.
  task automatic wr(input logic [7:0] val);
    @(negedge clk);
    cpSel = 1'b1;
    csN = 1'b0;
    wrN = 1'b0;
    dbIn = val;
    repeat (4) @(negedge clk);
    wrN = 1'b1;
    csN = 1'b1;
    dbIn = ~val;
    repeat (8) @(negedge clk);
  endtask
  // A read that never sees the drive enable hands back unknowns, so the compare fails.
  task automatic rd(output logic [7:0] val);
    int n;
    val = 8'hXX;
    n = 0;
    @(negedge clk);
    cpSel = 1'b1;
    csN = 1'b0;
    rdN = 1'b0;
    while (dbOe !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    if (dbOe === 1'b1) begin
      val = dbOut;
    end
    rdN = 1'b1;
    csN = 1'b1;
    repeat (8) @(negedge clk);
  endtask
endmodule

// File: dv/crt_status_bench.sv
// Self-checking bench for the status byte, display flags and counter preset.
`timescale 1ns/1ps
module crt_status_bench;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic csN, rdN, wrN, cpSel, dbOe;
  logic [7:0] dbIn, dbOut;
  logic irqOut, videoOut, dmaOut, blankOut, presetLoad, counterFreeze;
  logic [5:0] ev = 6'h00;
  int checks = 0;
  int mismatches = 0;
  int loadCycles = 0;
  always #10 clk = ~clk;
  crt_host_model host (.clk(clk), .csN(csN), .rdN(rdN), .wrN(wrN), .cpSel(cpSel), .dbIn(dbIn),
    .dbOut(dbOut), .dbOe(dbOe));
  crt_status crt_status_inst (.clk(clk), .rstn(rstn), .csN(csN), .rdN(rdN), .wrN(wrN), .cpSel(cpSel),
    .dbIn(dbIn), .dbOut(dbOut), .dbOe(dbOe), .lastRowStart(ev[0]), .vRetraceEnd(ev[1]),
    .penLoaded(ev[2]), .paramCountErr(ev[3]), .dmaLate(ev[4]), .fifoOverfill(ev[5]),
    .irqOut(irqOut), .videoOut(videoOut), .dmaOut(dmaOut), .blankOut(blankOut),
    .presetLoad(presetLoad), .counterFreeze(counterFreeze));
  always @(negedge clk) begin
    if (presetLoad === 1'b1) begin
      loadCycles++;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic status(input logic [7:0] exp);
    logic [7:0] v;
    host.rd(v);
    chk8(v, exp);
  endtask
  // Event pulses last one cycle and land from the falling edge, clear of the sampling edge.
  task automatic pulse(input logic [5:0] m);
    @(negedge clk);
    ev = m;
    @(negedge clk);
    ev = 6'h00;
  endtask
  task automatic conclude;
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    conclude();
  end
  initial begin
    repeat (6) @(negedge clk);
    rstn = 1'b1;
    repeat (6) @(negedge clk);
    status(8'h00);
    host.wr(crt_pkg::CMD_START);
    status(8'h44);
    chk1(videoOut, 1'b1);
    chk1(dmaOut, 1'b1);
    pulse(6'h01);
    chk1(irqOut, 1'b1);
    status(8'h64);
    chk1(irqOut, 1'b0);
    status(8'h44);
    pulse(6'h2C);
    status(8'h5D);
    status(8'h44);
    pulse(6'h10);
    chk1(blankOut, 1'b1);
    chk1(dmaOut, 1'b0);
    chk1(videoOut, 1'b0);
    status(8'h46);
    chk1(blankOut, 1'b1);
    pulse(6'h02);
    chk1(blankOut, 1'b0);
    chk1(videoOut, 1'b1);
    chk1(dmaOut, 1'b1);
    status(8'h44);
    host.wr(crt_pkg::CMD_STOP);
    status(8'h40);
    chk1(videoOut, 1'b0);
    pulse(6'h01);
    chk1(irqOut, 1'b1);
    status(8'h60);
    host.wr(crt_pkg::CMD_IRQ_OFF);
    status(8'h00);
    pulse(6'h01);
    chk1(irqOut, 1'b0);
    status(8'h00);
    host.wr(crt_pkg::CMD_IRQ_ON);
    status(8'h40);
    // The overrun pulse is timed onto the cycle in which the read clear fires.
    fork
      status(8'h40);
      begin
        @(posedge dbOe);
        repeat (4) @(negedge clk);
        pulse(6'h20);
      end
    join
    status(8'h41);
    loadCycles = 0;
    host.wr(crt_pkg::CMD_PRESET);
    chk8(8'(loadCycles), 8'h02);
    chk1(counterFreeze, 1'b1);
    repeat (20) @(negedge clk);
    chk1(counterFreeze, 1'b1);
    host.wr(crt_pkg::CMD_IRQ_ON);
    chk1(counterFreeze, 1'b0);
    host.wr(crt_pkg::CMD_START);
    status(8'h44);
    host.wr(crt_pkg::CMD_RESET);
    status(8'h00);
    chk1(videoOut, 1'b0);
    conclude();
  end
endmodule

// File: inc/crt_pkg.sv
// Shared constants and types for the CRT status and counter-preset block.
package crt_pkg;
  // Command bytes and the masks that select their opcode bits.
  localparam logic [7:0] CMD_RESET = 8'h00;
  localparam logic [7:0] CMD_START = 8'h20;
  localparam logic [7:0] MASK_OPC3 = 8'hE0;
  localparam logic [7:0] CMD_STOP = 8'h40;
  localparam logic [7:0] CMD_IRQ_ON = 8'hA0;
  localparam logic [7:0] CMD_IRQ_OFF = 8'hC0;
  localparam logic [7:0] CMD_PRESET = 8'hE0;
  localparam logic [7:0] MASK_FULL = 8'hFF;
  // The status byte sits at offset 0x1, selected by the command/parameter line high.
  localparam logic STATUS_SEL = 1'b1;
  // Status byte bit positions.
  localparam int BIT_ZERO = 7;
  localparam int BIT_IE = 6;
  localparam int BIT_IR = 5;
  localparam int BIT_LP = 4;
  localparam int BIT_IC = 3;
  localparam int BIT_VE = 2;
  localparam int BIT_DU = 1;
  localparam int BIT_FO = 0;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  // Preset time in character clocks; clk is the character clock.
  localparam int PRESET_CCLKS = 2;
  localparam int CLKS_PER_CCLK = 1;
  localparam int PRESET_CYCLES = PRESET_CCLKS * CLKS_PER_CCLK;
  localparam logic [1:0] PRESET_LAST = 2'(PRESET_CYCLES - 1);
  localparam logic [1:0] CNT_ZERO = 2'h0;
  localparam logic [1:0] CNT_ONE = 2'h1;
  // Pin vector width: select, read, write, port select and eight data bits.
  localparam int PIN_W = 12;
  localparam logic [PIN_W-1:0] PIN_IDLE = 12'hE00;
  // Positions of the strobes in the synchronised pin vector; the data byte sits below PIN_SEL.
  localparam int PIN_CS = 11;
  localparam int PIN_RD = 10;
  localparam int PIN_WR = 9;
  localparam int PIN_SEL = 8;
  typedef enum logic [2:0] {
    PS_IDLE = 3'b001,
    PS_LOAD = 3'b010,
    PS_HOLD = 3'b100
  } crt_pst_t;
endpackage

// File: inc/crt_preset_if.sv
// Handshake between the command decoder and the counter-preset sequencer.
`timescale 1ns/1ps
interface crt_preset_if;
  logic presetReq;
  logic otherCmd;
  logic presetLoad;
  logic frozen;
  modport ctl(output presetReq, output otherCmd, input presetLoad, input frozen);
  modport seq(input presetReq, input otherCmd, output presetLoad, output frozen);
endinterface

// File: logic/crt_preset.sv
// Counter-preset sequencer: loads the raster counters, then holds them frozen.
`timescale 1ns/1ps
module crt_preset (
  input wire logic clk,
  input wire logic rstn,
  crt_preset_if.seq pif
);
  crt_pkg::crt_pst_t state;
  crt_pkg::crt_pst_t next_state;
  logic [1:0] cnt;
  logic [1:0] next_cnt;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    unique case (state)
      crt_pkg::PS_IDLE: begin
        if (pif.presetReq) begin
          next_state = crt_pkg::PS_LOAD; // RULE1
          next_cnt = crt_pkg::CNT_ZERO;
        end
      end
      crt_pkg::PS_LOAD: begin
        // A command arriving mid-load is ignored so the load always completes.
        if (cnt == crt_pkg::PRESET_LAST) begin
          next_state = crt_pkg::PS_HOLD; // RULE2
        end else begin
          next_cnt = cnt + crt_pkg::CNT_ONE;
        end
      end
      crt_pkg::PS_HOLD: begin
        if (pif.presetReq) begin
          next_state = crt_pkg::PS_LOAD;
          next_cnt = crt_pkg::CNT_ZERO;
        end else if (pif.otherCmd) begin
          next_state = crt_pkg::PS_IDLE; // RULE3
        end
      end
      default: begin
        next_state = crt_pkg::PS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state <= crt_pkg::PS_IDLE;
      cnt <= crt_pkg::CNT_ZERO;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
    end
  end

  assign pif.presetLoad = (state == crt_pkg::PS_LOAD); // RULE1
  assign pif.frozen = (state != crt_pkg::PS_IDLE); // RULE3

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_start;
    state == crt_pkg::PS_IDLE && pif.presetReq;
  endsequence
  sequence s_load;
    pif.presetLoad [*2] ##1 !pif.presetLoad;
  endsequence

  a_load_two_cycles: assert property (s_start |=> s_load) // RULE2
    else $error("Preset load did not last two cycles.");
  a_hold_frozen: assert property ( // RULE3
    state == crt_pkg::PS_HOLD && !pif.otherCmd && !pif.presetReq |=> pif.frozen && !pif.presetLoad)
    else $error("Counters left the preset state without a command.");
  a_release_cmd: assert property ( // RULE3
    state == crt_pkg::PS_HOLD && pif.otherCmd && !pif.presetReq |=> !pif.frozen)
    else $error("Counters stayed frozen after another command.");
endmodule

// File: logic/crt_status.sv
// Status byte, display flags and command decoding for the CRT controller.
//
// Overview of operation
// RULE1 - Preset command loads the raster counters to the top-left screen position.
// RULE2 - Preset takes two character clocks; host waits before trusting counters.
// RULE3 - Counters stay frozen after preset until any other command arrives.
// RULE4 - Status read returns zero in bit 7 and seven flags below it.
// RULE5 - Interrupt-enable flag set or cleared by command; gates retrace interrupt.
// RULE6 - Start-display sets interrupt enable; reset command clears it.
// RULE7 - Last row start with interrupts enabled sets interrupt request.
// RULE8 - Interrupt request clears after a completed status read.
// RULE9 - Light-pen flag sets once position captured; clears after status read.
// RULE10 - Wrong parameter count sets improper-command flag; clears after status read.
// RULE11 - Video-enable flag set by start, cleared by stop or reset.
// RULE12 - Late DMA data sets underrun flag; clears after status read.
// RULE13 - Underrun stops DMA and blanks screen until next vertical retrace ends.
// RULE14 - FIFO overfill sets overrun flag; clears on status read.
// RULE15 - Preset command is byte 0xE0 on the command port, no parameters.
// RULE16 - Stop-display disables video only; interrupts and retrace keep running.
// RULE17 - Start-display enables interrupts, DMA requests and video.
// RULE18 - Read-cleared flags clear after the read ends; byte shows start values.
`timescale 1ns/1ps
module crt_status (
  input wire logic clk,
  input wire logic rstn,
  input wire logic csN,
  input wire logic rdN,
  input wire logic wrN,
  input wire logic cpSel,
  input wire logic [7:0] dbIn,
  output logic [7:0] dbOut,
  output logic dbOe,
  input wire logic lastRowStart,
  input wire logic vRetraceEnd,
  input wire logic penLoaded,
  input wire logic paramCountErr,
  input wire logic dmaLate,
  input wire logic fifoOverfill,
  output logic irqOut,
  output logic videoOut,
  output logic dmaOut,
  output logic blankOut,
  output logic presetLoad,
  output logic counterFreeze
);
  localparam int W = crt_pkg::PIN_W;

  // Pin synchroniser: three stages, a bit changes once stages two and three agree.
  logic [W-1:0] syn1, syn2, syn3, pinF;
  logic [W-1:0] next_pinF;
  logic rdAct, wrAct, rdActD, wrActD, rdStart, rdEnd, wrEnd;
  logic [7:0] cmdHold, next_cmdHold;
  logic ie, ir, lp, ic, ve, du, fo, blank, dmaEn;
  logic next_ie, next_ir, next_lp, next_ic, next_ve, next_du, next_fo, next_blank, next_dmaEn;
  logic [7:0] status, next_dbOut;
  logic cmdReset, cmdStart, cmdStop, cmdIrqOn, cmdIrqOff, cmdPreset;
  crt_preset_if pif();

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_pinF = ((syn2 ~^ syn3) & syn3) | ((syn2 ^ syn3) & pinF);
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      syn1 <= crt_pkg::PIN_IDLE;
      syn2 <= crt_pkg::PIN_IDLE;
      syn3 <= crt_pkg::PIN_IDLE;
      pinF <= crt_pkg::PIN_IDLE;
    end else begin
      syn1 <= {csN, rdN, wrN, cpSel, dbIn};
      syn2 <= syn1;
      syn3 <= syn2;
      pinF <= next_pinF;
    end
  end

  // Status lives at the select-high port; reads at the other port are not ours.
  assign rdAct = !pinF[crt_pkg::PIN_CS] && !pinF[crt_pkg::PIN_RD]
    && (pinF[crt_pkg::PIN_SEL] == crt_pkg::STATUS_SEL); // RULE4
  assign wrAct = !pinF[crt_pkg::PIN_CS] && !pinF[crt_pkg::PIN_WR]
    && (pinF[crt_pkg::PIN_SEL] == crt_pkg::STATUS_SEL);
  // An event landing inside the read window is cleared unseen; the host only sees it if it fires again.
  assign rdStart = rdAct && !rdActD;
  assign rdEnd = !rdAct && rdActD;
  assign wrEnd = !wrAct && wrActD;

  ////////////////////////////////////////////////////////////////////////////
  // Commands act when the write strobe ends, with the byte held during it.
  always_comb begin
    next_cmdHold = wrAct ? pinF[crt_pkg::PIN_SEL-1:0] : cmdHold;
  end

  assign cmdReset = wrEnd && ((cmdHold & crt_pkg::MASK_OPC3) == crt_pkg::CMD_RESET);
  assign cmdStart = wrEnd && ((cmdHold & crt_pkg::MASK_OPC3) == crt_pkg::CMD_START);
  assign cmdStop = wrEnd && (cmdHold == crt_pkg::CMD_STOP);
  assign cmdIrqOn = wrEnd && (cmdHold == crt_pkg::CMD_IRQ_ON);
  assign cmdIrqOff = wrEnd && (cmdHold == crt_pkg::CMD_IRQ_OFF);
  assign cmdPreset = wrEnd && ((cmdHold & crt_pkg::MASK_FULL) == crt_pkg::CMD_PRESET); // RULE15

  assign pif.presetReq = cmdPreset; // RULE1
  assign pif.otherCmd = wrEnd && !cmdPreset; // RULE3

  crt_preset crt_preset_inst (
    .clk(clk),
    .rstn(rstn),
    .pif(pif)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    status = crt_pkg::STATUS_RESET;
    status[crt_pkg::BIT_IE] = ie;
    status[crt_pkg::BIT_IR] = ir;
    status[crt_pkg::BIT_LP] = lp;
    status[crt_pkg::BIT_IC] = ic;
    status[crt_pkg::BIT_VE] = ve;
    status[crt_pkg::BIT_DU] = du;
    status[crt_pkg::BIT_FO] = fo;
    status[crt_pkg::BIT_ZERO] = 1'b0; // RULE4
  end

  // A set arriving in the clearing cycle wins, so that event is not lost.
  always_comb begin
    next_dbOut = rdStart ? status : dbOut; // RULE18
    next_ie = ie;
    if (cmdStart || cmdIrqOn) begin
      next_ie = 1'b1; // RULE6 RULE17
    end else if (cmdReset || cmdIrqOff) begin
      next_ie = 1'b0; // RULE5
    end
    next_ve = ve;
    if (cmdStart) begin
      next_ve = 1'b1; // RULE11
    end else if (cmdStop || cmdReset) begin
      next_ve = 1'b0; // RULE16
    end
    next_ir = (ir && !rdEnd) || (lastRowStart && ie); // RULE7 RULE8
    next_lp = (lp && !rdEnd) || penLoaded; // RULE9
    next_ic = (ic && !rdEnd) || paramCountErr; // RULE10
    next_du = (du && !rdEnd) || dmaLate; // RULE12
    next_fo = (fo && !rdEnd) || fifoOverfill; // RULE14
    next_blank = blank;
    if (dmaLate) begin
      next_blank = 1'b1; // RULE13
    end else if (vRetraceEnd || cmdReset) begin
      next_blank = 1'b0;
    end
    next_dmaEn = dmaEn;
    if (cmdStart) begin
      next_dmaEn = 1'b1; // RULE17
    end else if (cmdReset) begin
      next_dmaEn = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rdActD <= 1'b0;
      wrActD <= 1'b0;
      cmdHold <= crt_pkg::STATUS_RESET;
      dbOut <= crt_pkg::STATUS_RESET;
      {ie, ir, lp, ic, ve, du, fo} <= 7'h00;
      blank <= 1'b0;
      dmaEn <= 1'b0;
      dbOe <= 1'b0;
      irqOut <= 1'b0;
      videoOut <= 1'b0;
      dmaOut <= 1'b0;
    end else begin
      rdActD <= rdAct;
      wrActD <= wrAct;
      cmdHold <= next_cmdHold;
      dbOut <= next_dbOut;
      {ie, ir, lp, ic, ve, du, fo} <= {next_ie, next_ir, next_lp, next_ic, next_ve, next_du, next_fo};
      blank <= next_blank;
      dmaEn <= next_dmaEn;
      dbOe <= rdAct;
      irqOut <= next_ir; // RULE5
      videoOut <= next_ve && !next_blank; // RULE13
      // DMA pauses while blanked and picks up again after the retrace that ends it.
      dmaOut <= next_dmaEn && !next_blank; // RULE13
    end
  end

  assign blankOut = blank;
  assign presetLoad = pif.presetLoad;
  // Any command other than preset, stop-display included, releases the freeze.
  assign counterFreeze = pif.frozen; // RULE3

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_bit7_zero: assert property (dbOe |-> !dbOut[crt_pkg::BIT_ZERO]) // RULE4
    else $error("Status bit 7 read as one.");
  a_snapshot: assert property (rdStart |=> dbOut == $past(status)) // RULE18
    else $error("Status byte does not match flags at read start.");
  a_irq_gate: assert property ($rose(ir) |-> $past(ie) && $past(lastRowStart)) // RULE5
    else $error("Interrupt request raised without permission.");
  sequence s_read_end_quiet;
    rdEnd && !lastRowStart && !dmaLate && !fifoOverfill;
  endsequence

  a_irq_set: assert property (lastRowStart && ie |=> ir && irqOut) // RULE7
    else $error("Interrupt request not raised at last row.");
  a_rd_clear: assert property (s_read_end_quiet |=> !ir && !du && !fo) // RULE8
    else $error("Read-cleared flags survived the read.");
  a_pen_cmd_clear: assert property (rdEnd && !penLoaded && !paramCountErr |=> !lp && !ic) // RULE10
    else $error("Pen or improper-command flag survived the read.");
  a_set_wins: assert property (rdEnd && fifoOverfill |=> fo) // RULE14
    else $error("Overrun lost when it met the read clear.");
  a_oe_read: assert property (rdStart |=> dbOe) // RULE4
    else $error("Status byte not driven during a read.");
  a_start_flags: assert property (cmdStart |=> ie && ve && dmaEn) // RULE17
    else $error("Start-display did not set its flags.");
  a_stop_keeps: assert property (cmdStop |=> !ve && ie == $past(ie)) // RULE16
    else $error("Stop-display handled flags wrongly.");
  a_reset_cmd: assert property (cmdReset |=> !ie && !ve) // RULE6
    else $error("Reset command did not clear enable flags.");
  a_du_blank: assert property (dmaLate |=> du && blank && !dmaOut && !videoOut) // RULE13
    else $error("Underrun did not stop DMA and blank.");
  a_blank_release: assert property (blank && vRetraceEnd && !dmaLate |=> !blank && videoOut == ve) // RULE13
    else $error("Blanking did not end after the retrace.");
  a_flag_sets: assert property (fifoOverfill && penLoaded && paramCountErr |=> fo && lp && ic) // RULE9
    else $error("Event flags not set.");
endmodule
